// File: spir_pkg.sv
package spir_pkg;

	// ***********************************************************
	// geometry
	// ***********************************************************
	localparam int          NUM_PORTS_DEF = 3;
	localparam int          MAX_PORTS     = 3;
	localparam int          PORT_IDX_W    = 2;
	localparam int          REG_ADDR_W    = 16;
	localparam int          REG_DATA_W    = 32;
	localparam int          STATE_W       = 2;
	localparam int          TC_W          = 2;
	localparam int          PRIO_W        = 3;
	localparam int          TC_MAP_W      = 16;

	// ***********************************************************
	// register numbers
	// ***********************************************************
	localparam logic [15:0] ADDR_PORT_INGRESS = 16'h1841;
	localparam logic [15:0] ADDR_ADMIT_TAGGED = 16'h1842;
	localparam logic [15:0] ADDR_PORT_STATE   = 16'h1843;
	localparam logic [15:0] ADDR_PRIO_QUEUE   = 16'h1845;

	// ***********************************************************
	// field positions
	// ***********************************************************
	localparam int          LEARN_LSB  = 3;
	localparam int          CHECK_LSB  = 0;
	localparam int          TAGGED_LSB = 0;
	localparam int          STATE_LSB  = 0;
	localparam int          PRIO_LSB   = 0;

	// ***********************************************************
	// reset values
	// ***********************************************************
	localparam logic [2:0]  LEARN_RST  = 3'h7;
	localparam logic [2:0]  CHECK_RST  = 3'h0;
	localparam logic [2:0]  TAGGED_RST = 3'h0;
	localparam logic [5:0]  STATE_RST  = 6'h00;
	localparam logic [15:0] PRIO_RST   = 16'hFA41;

	// ***********************************************************
	// spanning tree state codes
	// ***********************************************************
	localparam logic [1:0]  STP_FORWARD  = 2'h0;
	localparam logic [1:0]  STP_BLOCKING = 2'h1;
	localparam logic [1:0]  STP_LEARNING = 2'h2;
	localparam logic [1:0]  STP_DISABLED = 2'h3;

	function automatic logic spir_may_learn(input logic [1:0] st);
		return (st == STP_FORWARD) || (st == STP_LEARNING);
	endfunction

endpackage

// File: spir_frame_check.sv
`timescale 1ns/1ps
module spir_frame_check
	import spir_pkg::*;
#(
	parameter int NUM_PORTS = NUM_PORTS_DEF
) (
	input  wire logic [NUM_PORTS-1:0]         learn_en,
	input  wire logic [NUM_PORTS-1:0]         check_en,
	input  wire logic [NUM_PORTS-1:0]         tagged_only,
	input  wire logic [NUM_PORTS-1:0]         admit_non_member,
	input  wire logic [STATE_W*NUM_PORTS-1:0] port_state,
	input  wire logic [TC_MAP_W-1:0]          prio_map,
	input  wire logic                         vlan_en,
	input  wire logic [PORT_IDX_W-1:0]        port,
	input  wire logic                         has_tag,
	input  wire logic                         vid_zero,
	input  wire logic                         vlan_active,
	input  wire logic                         ing_member,
	input  wire logic                         da_found,
	input  wire logic                         egr_member,
	input  wire logic [PRIO_W-1:0]            prio,
	output logic                              drop,
	output logic                              drop_untagged,
	output logic                              drop_member,
	output logic                              learn,
	output logic [TC_W-1:0]                   queue
);

	logic port_ok;
	logic check;
	logic ing_fail;
	logic egr_fail;
	int   pi;

	always_comb begin
		port_ok = (32'(port) < NUM_PORTS);
		pi = port_ok ? int'(port) : 0;
		// untagged or priority-tagged frames
		drop_untagged = port_ok && vlan_en && tagged_only[pi]
			&& (!has_tag || vid_zero);
		// check bits are inert without the global enable
		check = port_ok && vlan_en && check_en[pi];
		// non-member admitted only into an active vlan
		ing_fail = !ing_member && !(admit_non_member[pi] && vlan_active);
		// egress side only for known destinations
		egr_fail = da_found && !egr_member;
		drop_member = check && (ing_fail || egr_fail);
		// unknown port index cannot be served, so frame is dropped
		drop = !port_ok || drop_untagged || drop_member;
		// learning gated by enable and tree state
		learn = port_ok && learn_en[pi]
			&& spir_may_learn(port_state[STATE_W*pi +: STATE_W]);
		queue = prio_map[TC_W*int'(prio) +: TC_W];
	end

endmodule

// File: spir_ingress_rules.sv
`timescale 1ns/1ps
// Functional notes
// - an enabled port learns source addresses; the enables reset to one.
// - a port learns only in the forwarding or learning tree state.
// - learning enables sit at bits 5,4,3 for ports 2,1,0.
// - membership checking is enabled per port by bits 2,1,0, reset zero.
// - frames from a non-member ingress port drop unless admitted.
// - known destinations also need a member egress port to pass.
// - membership checking is inert while the global vlan enable is clear.
// - with vlan on, tagged-only ports drop untagged and priority frames.
// - tree states sit at bits 5:4, 3:2, 1:0 and reset to forwarding.
// - state codes 0 to 3 are forwarding, blocking, learning, disabled.
// - priority p picks its egress queue from map bits 2p+1 to 2p.
// - the queue map resets to 3,3,2,2,1,0,0,1 for priorities 7 to 0.
// - vlan ingress rules need the global vlan enable, which resets clear.
// - admit-non-member passes a non-member port if the vlan is active.
module spir_ingress_rules
	import spir_pkg::*;
#(
	parameter int NUM_PORTS = NUM_PORTS_DEF
) (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic [REG_ADDR_W-1:0] reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [REG_DATA_W-1:0] reg_wdata,
	output logic      [REG_DATA_W-1:0] reg_rdata,
	output logic                       reg_rvalid,
	input  wire logic                  vlan_en,
	input  wire logic [NUM_PORTS-1:0]  admit_non_member,
	input  wire logic                  frm_valid,
	input  wire logic [PORT_IDX_W-1:0] frm_port,
	input  wire logic                  frm_has_tag,
	input  wire logic                  frm_vid_zero,
	input  wire logic                  frm_vlan_active,
	input  wire logic                  frm_ing_member,
	input  wire logic                  frm_da_found,
	input  wire logic                  frm_egr_member,
	input  wire logic [PRIO_W-1:0]     frm_prio,
	output logic                       out_valid,
	output logic [PORT_IDX_W-1:0]      out_port,
	output logic                       out_drop,
	output logic                       out_drop_untagged,
	output logic                       out_drop_member,
	output logic                       out_learn,
	output logic [TC_W-1:0]            out_queue
);

	// ***********************************************************
	// elaboration checks
	// ***********************************************************
	generate
		if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS) begin : g_bad
			$error("NUM_PORTS must be 1 to 3");
		end
	endgenerate

	// ***********************************************************
	// register file
	// ***********************************************************
	logic [NUM_PORTS-1:0]         learn_en;
	logic [NUM_PORTS-1:0]         check_en;
	logic [NUM_PORTS-1:0]         tagged_only;
	logic [STATE_W*NUM_PORTS-1:0] port_state;
	logic [TC_MAP_W-1:0]          prio_map;

	function automatic logic reg_hit(input logic [REG_ADDR_W-1:0] a,
		input logic [REG_ADDR_W-1:0] r);
		return a == r;
	endfunction

	// only the implemented field bits are stored
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			learn_en <= LEARN_RST[NUM_PORTS-1:0];
			check_en <= CHECK_RST[NUM_PORTS-1:0];
		end else if (reg_wr && reg_hit(reg_addr, ADDR_PORT_INGRESS)) begin
			learn_en <= reg_wdata[LEARN_LSB +: NUM_PORTS];
			check_en <= reg_wdata[CHECK_LSB +: NUM_PORTS];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tagged_only <= TAGGED_RST[NUM_PORTS-1:0];
		end else if (reg_wr && reg_hit(reg_addr, ADDR_ADMIT_TAGGED)) begin
			tagged_only <= reg_wdata[TAGGED_LSB +: NUM_PORTS];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			port_state <= STATE_RST[STATE_W*NUM_PORTS-1:0];
		end else if (reg_wr && reg_hit(reg_addr, ADDR_PORT_STATE)) begin
			port_state <= reg_wdata[STATE_LSB +: STATE_W*NUM_PORTS];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prio_map <= PRIO_RST;
		end else if (reg_wr && reg_hit(reg_addr, ADDR_PRIO_QUEUE)) begin
			prio_map <= reg_wdata[PRIO_LSB +: TC_MAP_W];
		end
	end

	// ***********************************************************
	// read back
	// ***********************************************************
	logic [REG_DATA_W-1:0] next_rdata;

	// unmapped numbers and reserved bits read as zero
	always_comb begin
		next_rdata = '0;
		if (reg_hit(reg_addr, ADDR_PORT_INGRESS)) begin
			next_rdata[LEARN_LSB +: NUM_PORTS] = learn_en;
			next_rdata[CHECK_LSB +: NUM_PORTS] = check_en;
		end else if (reg_hit(reg_addr, ADDR_ADMIT_TAGGED)) begin
			next_rdata[TAGGED_LSB +: NUM_PORTS] = tagged_only;
		end else if (reg_hit(reg_addr, ADDR_PORT_STATE)) begin
			next_rdata[STATE_LSB +: STATE_W*NUM_PORTS] = port_state;
		end else if (reg_hit(reg_addr, ADDR_PRIO_QUEUE)) begin
			next_rdata[PRIO_LSB +: TC_MAP_W] = prio_map;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata  <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// ***********************************************************
	// frame decision
	// ***********************************************************
	logic            next_drop;
	logic            next_drop_untagged;
	logic            next_drop_member;
	logic            next_learn;
	logic [TC_W-1:0] next_queue;

	spir_frame_check #(
		.NUM_PORTS(NUM_PORTS)
	) u_check (
		.learn_en         (learn_en),
		.check_en         (check_en),
		.tagged_only      (tagged_only),
		.admit_non_member (admit_non_member),
		.port_state       (port_state),
		.prio_map         (prio_map),
		.vlan_en          (vlan_en),
		.port             (frm_port),
		.has_tag          (frm_has_tag),
		.vid_zero         (frm_vid_zero),
		.vlan_active      (frm_vlan_active),
		.ing_member       (frm_ing_member),
		.da_found         (frm_da_found),
		.egr_member       (frm_egr_member),
		.prio             (frm_prio),
		.drop             (next_drop),
		.drop_untagged    (next_drop_untagged),
		.drop_member      (next_drop_member),
		.learn            (next_learn),
		.queue            (next_queue)
	);

	// one cycle of latency; results hold until the next frame
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			out_valid         <= 1'b0;
			out_port          <= '0;
			out_drop          <= 1'b0;
			out_drop_untagged <= 1'b0;
			out_drop_member   <= 1'b0;
			out_learn         <= 1'b0;
			out_queue         <= '0;
		end else begin
			out_valid <= frm_valid;
			if (frm_valid) begin
				out_port          <= frm_port;
				out_drop          <= next_drop;
				out_drop_untagged <= next_drop_untagged;
				out_drop_member   <= next_drop_member;
				out_learn         <= next_learn;
				out_queue         <= next_queue;
			end
		end
	end

	// ***********************************************************
	// assertions
	// ***********************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic            frm_port_ok;
	logic [TC_W-1:0] exp_queue;
	assign frm_port_ok = (32'(frm_port) < NUM_PORTS);
	assign exp_queue   = prio_map[TC_W*int'(frm_prio) +: TC_W];

	chk_reset_values: assert property (
		$rose(rst_b) |-> learn_en == LEARN_RST[NUM_PORTS-1:0]
			&& check_en == '0 && tagged_only == '0
			&& port_state == '0 && prio_map == PRIO_RST)
		else $error("configuration not at reset values");

	chk_learn_gate: assert property (
		out_valid && out_learn |->
			$past(port_state[STATE_W*int'(frm_port) +: STATE_W]) != STP_BLOCKING
			&& $past(port_state[STATE_W*int'(frm_port) +: STATE_W])
				!= STP_DISABLED)
		else $error("learned in blocking or disabled state");

	chk_learn_enable: assert property (
		frm_valid && frm_port_ok && learn_en[frm_port]
			&& port_state[STATE_W*int'(frm_port) +: STATE_W] == STP_FORWARD
			|=> out_valid && out_learn && out_port == $past(frm_port))
		else $error("enabled forwarding port did not learn");

	chk_untagged_drop: assert property (
		frm_valid && vlan_en && frm_port_ok && tagged_only[frm_port]
			&& (!frm_has_tag || frm_vid_zero)
			|=> out_valid && out_drop && out_drop_untagged)
		else $error("untagged frame not dropped");

	chk_vlan_off: assert property (
		frm_valid && !vlan_en && frm_port_ok |=> out_valid && !out_drop)
		else $error("vlan rules applied while disabled");

	chk_ingress_member: assert property (
		frm_valid && vlan_en && frm_port_ok && check_en[frm_port]
			&& !frm_ing_member && !admit_non_member[frm_port]
			|=> out_drop && out_drop_member)
		else $error("ingress non-member not dropped");

	chk_egress_member: assert property (
		frm_valid && vlan_en && frm_port_ok && check_en[frm_port]
			&& frm_da_found && !frm_egr_member |=> out_drop_member)
		else $error("egress non-member not dropped");

	chk_admit_nonmem: assert property (
		frm_valid && vlan_en && frm_port_ok && frm_vlan_active
			&& admit_non_member[frm_port] && !frm_da_found
			&& !tagged_only[frm_port] |=> !out_drop)
		else $error("admitted non-member was dropped");

	chk_queue_map: assert property (
		frm_valid |=> out_queue == $past(exp_queue))
		else $error("wrong egress queue");

	chk_reserved_zero: assert property (
		reg_rd && reg_hit(reg_addr, ADDR_PRIO_QUEUE)
			|=> reg_rvalid && reg_rdata[REG_DATA_W-1:TC_MAP_W] == '0
			&& reg_rdata[TC_MAP_W-1:0] == $past(prio_map))
		else $error("reserved bits not zero");

	cov_learn:     cover property (out_valid && out_learn);
	cov_tag_drop:  cover property (out_valid && out_drop_untagged);
	cov_mem_drop:  cover property (out_valid && out_drop_member);
	cov_queue_top: cover property (out_valid && out_queue == 2'h3);

endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
	import spir_pkg::*;

	typedef struct packed {
		logic [1:0] port;
		logic       bad;
		logic       drop;
		logic       du;
		logic       dm;
		logic       learn;
		logic [1:0] queue;
	} spir_tb_exp_t;

	// ****************
	// stimulus and dut
	// ****************
	logic        clk              = 1'b0;
	logic        rst_b            = 1'b0;
	logic [15:0] reg_addr         = 16'h0000;
	logic        reg_wr           = 1'b0;
	logic        reg_rd           = 1'b0;
	logic [31:0] reg_wdata        = 32'h0000_0000;
	logic [31:0] reg_rdata;
	logic        reg_rvalid;
	logic        vlan_en          = 1'b0;
	logic [2:0]  admit_non_member = 3'h0;
	logic        frm_valid        = 1'b0;
	logic [1:0]  frm_port         = 2'h0;
	logic        frm_has_tag      = 1'b0;
	logic        frm_vid_zero     = 1'b0;
	logic        frm_vlan_active  = 1'b0;
	logic        frm_ing_member   = 1'b0;
	logic        frm_da_found     = 1'b0;
	logic        frm_egr_member   = 1'b0;
	logic [2:0]  frm_prio         = 3'h0;
	logic        out_valid;
	logic [1:0]  out_port;
	logic        out_drop;
	logic        out_drop_untagged;
	logic        out_drop_member;
	logic        out_learn;
	logic [1:0]  out_queue;
	logic [2:0]  sh_learn         = LEARN_RST;
	logic [2:0]  sh_check         = CHECK_RST;
	logic [2:0]  sh_tagged        = TAGGED_RST;
	logic [5:0]  sh_state         = STATE_RST;
	logic [15:0] sh_prio          = PRIO_RST;
	logic [15:0] addrs [6]        = '{16'h1841, 16'h1842, 16'h1843,
	                                  16'h1845, 16'h1844, 16'h1840};
	spir_tb_exp_t exp_q [$];
	logic [31:0]  rd_q  [$];
	spir_tb_exp_t got;
	int           num_errors  = 0;
	int           comparisons = 0;
	int           k;

	always #2 clk = ~clk;

	spir_ingress_rules #(.NUM_PORTS(3)) uut (
		.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .vlan_en(vlan_en),
		.admit_non_member(admit_non_member), .frm_valid(frm_valid),
		.frm_port(frm_port), .frm_has_tag(frm_has_tag),
		.frm_vid_zero(frm_vid_zero), .frm_vlan_active(frm_vlan_active),
		.frm_ing_member(frm_ing_member), .frm_da_found(frm_da_found),
		.frm_egr_member(frm_egr_member), .frm_prio(frm_prio),
		.out_valid(out_valid), .out_port(out_port), .out_drop(out_drop),
		.out_drop_untagged(out_drop_untagged),
		.out_drop_member(out_drop_member), .out_learn(out_learn),
		.out_queue(out_queue));

	// ****************
	// reference model
	// ****************
	// reserved bits must come back zero whatever was written
	function automatic logic [31:0] rd_model(input logic [15:0] a);
		case (a)
			ADDR_PORT_INGRESS: return {26'h0, sh_learn, sh_check};
			ADDR_ADMIT_TAGGED: return {29'h0, sh_tagged};
			ADDR_PORT_STATE:   return {26'h0, sh_state};
			ADDR_PRIO_QUEUE:   return {16'h0, sh_prio};
			default:           return 32'h0;
		endcase
	endfunction

	task automatic fail(input string m);
		num_errors++;
		$display("ERROR at %0t: %s", $time, m);
	endtask

	// one call per cycle keeps every strobe assigned once per time step
	task automatic drive(input logic w, input logic r, input logic [15:0] a,
			input logic [31:0] d, input logic f);
		spir_tb_exp_t e;
		logic [1:0]   p;
		logic [2:0]   pr;
		logic [2:0]   anm;
		logic [6:0]   b;
		logic [1:0]   st;
		p = ($urandom % 6 == 0) ? 2'h3 : 2'($urandom % 3);
		pr = 3'($urandom);
		anm = 3'($urandom);
		b = 7'($urandom);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		frm_valid <= f;
		frm_port <= p;
		frm_prio <= pr;
		admit_non_member <= anm;
		{vlan_en, frm_has_tag, frm_vid_zero, frm_vlan_active} <= b[6:3];
		{frm_ing_member, frm_da_found, frm_egr_member} <= b[2:0];
		if (r)
			rd_q.push_back(rd_model(a));
		if (f) begin
			st = sh_state[2*p+:2];
			e.port = p;
			e.bad = (p == 2'h3);
			e.du = b[6] & sh_tagged[p] & (!b[5] | b[4]);
			e.dm = b[6] & sh_check[p] & ((!b[2] & !(anm[p] & b[3]))
				| (b[1] & !b[0]));
			e.drop = e.bad | e.du | e.dm;
			e.learn = !e.bad & sh_learn[p]
				& (st == 2'h0 || st == 2'h2);
			e.queue = sh_prio[2*pr+:2];
			exp_q.push_back(e);
		end
		if (w) begin
			case (a)
				ADDR_PORT_INGRESS: {sh_learn, sh_check} = d[5:0];
				ADDR_ADMIT_TAGGED: sh_tagged = d[2:0];
				ADDR_PORT_STATE:   sh_state = d[5:0];
				ADDR_PRIO_QUEUE:   sh_prio = d[15:0];
				default:           ;
			endcase
		end
	endtask

	// ****************
	// monitor
	// ****************
	always @(negedge clk) begin
		if (rst_b === 1'b1 && reg_rvalid === 1'b1) begin
			comparisons++;
			if (rd_q.size() == 0)
				fail("read data without a read");
			else if (reg_rdata !== rd_q.pop_front())
				fail("register read data differs");
		end
		if (rst_b === 1'b1 && out_valid === 1'b1) begin
			comparisons++;
			if (exp_q.size() == 0)
				fail("decision without a frame");
			else begin
				got = exp_q.pop_front();
				if (out_port !== got.port || out_drop !== got.drop)
					fail("drop decision differs");
				if (!got.bad && {out_drop_untagged, out_drop_member}
					!== {got.du, got.dm})
					fail("drop cause differs");
				if (out_learn !== got.learn)
					fail("learn decision differs");
				if (!got.bad && out_queue !== got.queue)
					fail("egress queue differs");
			end
		end
	end

	task automatic final_report();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		fail("watchdog expired");
		final_report();
	end

	initial begin
		void'($urandom(38080));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		foreach (addrs[i])
			drive(1'b0, 1'b1, addrs[i], 32'h0, 1'b1);
		foreach (addrs[i]) begin
			drive(1'b1, 1'b1, addrs[i], 32'hFFFF_FFFF, 1'b1);
			drive(1'b0, 1'b1, addrs[i], 32'h0, 1'b1);
		end
		// random mix of writes, reads and back-to-back frames
		for (int n = 0; n < 3000; n++) begin
			k = $urandom % 8;
			drive(k < 2, k == 1 || k == 2, addrs[$urandom % 6],
				$urandom, k != 2);
		end
		drive(1'b0, 1'b0, 16'h0000, 32'h0, 1'b0);
		repeat (3) @(posedge clk);
		if (exp_q.size() != 0 || rd_q.size() != 0)
			fail("answers missing at end");
		final_report();
	end
endmodule
